// file: src/cce_execute.sv
// Behaviour
// RULE1 - A call pushes the address after the call (pc plus one) unconditionally and touches no status flag.
// RULE2 - After the push a call loads the program counter with its target so fetching continues there.
// RULE3 - A call occupies two instruction cycles.
// RULE4 - Byte clear writes 00H to the addressed data byte and leaves the status flags alone.
// RULE5 - Bit clear forces only the selected bit of the addressed byte to 0, keeping the rest and the flags.
// RULE6 - Single watchdog clear resets the watchdog counter and clears the time-out and power-down flags.
// RULE7 - The first pre-clear half acts only when alternating with the second, and the pair clears counter and flags.
// RULE8 - The second pre-clear half acts only when alternating with the first, then clears counter and flags.
// RULE9 - Repeats of the same pre-clear half without the other between have no effect.
// RULE10 - Flags are cleared only after both halves ran consecutively, otherwise they keep their values.
// RULE11 - The record of the last pre-clear half returns to idle on reset.
`timescale 1ns/1ps
`default_nettype none
module cce_execute #(
    parameter int PC_WIDTH       = cce_pkg::PC_WIDTH,
    parameter int MEM_ADDR_WIDTH = cce_pkg::MEM_ADDR_WIDTH,
    parameter int DATA_WIDTH     = cce_pkg::DATA_WIDTH,
    parameter int BIT_SEL_WIDTH  = cce_pkg::BIT_SEL_WIDTH
) (
    input  wire logic                      ref_clk_i,
    input  wire logic                      nrst_i,
    input  wire logic                      instr_valid_i,
    input  wire logic [2:0]                instr_op_i,
    input  wire logic [PC_WIDTH-1:0]       pc_i,
    input  wire logic [PC_WIDTH-1:0]       call_target_i,
    input  wire logic [MEM_ADDR_WIDTH-1:0] mem_addr_i,
    input  wire logic [BIT_SEL_WIDTH-1:0]  bit_sel_i,
    input  wire logic                      timeout_set_i,
    input  wire logic                      powerdown_set_i,
    output logic                           instr_ready_o,
    output logic                           stack_push_o,
    output logic [PC_WIDTH-1:0]            stack_data_o,
    output logic                           pc_load_o,
    output logic [PC_WIDTH-1:0]            pc_load_addr_o,
    output logic                           mem_we_o,
    output logic [MEM_ADDR_WIDTH-1:0]      mem_addr_o,
    output logic [DATA_WIDTH-1:0]          mem_wdata_o,
    output logic [DATA_WIDTH-1:0]          mem_wmask_o,
    output logic                           watchdog_counter_clear_o,
    output logic                           timeout_status_flag_o,
    output logic                           powerdown_status_flag_o,
    output logic                           preclear_armed_o
);

    cce_pkg::cce_exec_type     exec_state;
    logic                      accept;
    logic                      do_call;
    logic                      do_byte_zero;
    logic                      do_bit_zero;
    logic                      do_single_clear;
    logic                      do_first_half;
    logic                      do_second_half;
    logic                      pair_fire;
    logic                      pair_armed;
    logic                      flag_clear;
    logic [PC_WIDTH-1:0]       return_addr;
    logic [PC_WIDTH-1:0]       jump_target;

    // Decode helper: instruction of a given class taken this cycle
    function automatic logic op_hit(input logic taken, input logic [2:0] op, input logic [2:0] code);
        op_hit = taken && (op == code);
    endfunction

    // One-hot write mask for the selected bit position
    function automatic logic [DATA_WIDTH-1:0] bit_mask(input logic [BIT_SEL_WIDTH-1:0] sel);
        bit_mask = '0;
        for (int i = 0; i < DATA_WIDTH; i++) begin
            if (sel == BIT_SEL_WIDTH'(i)) begin
                bit_mask[i] = 1'b1;
            end
        end
    endfunction

    // Requests are only taken in the issue phase; the call's jump cycle refuses them
    assign accept          = instr_valid_i && (exec_state == cce_pkg::CCE_EXEC_ISSUE);
    assign do_call         = op_hit(accept, instr_op_i, cce_pkg::OP_CALL);
    assign do_byte_zero    = op_hit(accept, instr_op_i, cce_pkg::OP_MEMORY_BYTE_ZERO);
    assign do_bit_zero     = op_hit(accept, instr_op_i, cce_pkg::OP_MEMORY_BIT_ZERO);
    assign do_single_clear = op_hit(accept, instr_op_i, cce_pkg::OP_WATCHDOG_CLEAR_SINGLE);
    assign do_first_half   = op_hit(accept, instr_op_i, cce_pkg::OP_WATCHDOG_PRECLEAR_FIRST);
    assign do_second_half  = op_hit(accept, instr_op_i, cce_pkg::OP_WATCHDOG_PRECLEAR_SECOND);

    // Return address wraps with the program counter width
    assign return_addr = pc_i + PC_WIDTH'(cce_pkg::RETURN_OFFSET); // [RULE1]

    // Paired pre-clear bookkeeping
    cce_pair_tracker u_pair (
        .ref_clk_i (ref_clk_i),
        .nrst_i    (nrst_i),
        .first_i   (do_first_half),
        .second_i  (do_second_half),
        .fire_o    (pair_fire),
        .armed_o   (pair_armed)
    );

    // Only the watchdog clears reach the flags; call and memory clears never do
    assign flag_clear = do_single_clear || pair_fire; // [RULE6] [RULE7] [RULE8] [RULE10]

    // Execution phase: a call spends its second cycle loading the counter
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            exec_state <= cce_pkg::CCE_EXEC_ISSUE;
        end else begin
            case (exec_state)
                cce_pkg::CCE_EXEC_ISSUE: begin
                    if (do_call) begin
                        exec_state <= cce_pkg::CCE_EXEC_CALL_JUMP; // [RULE3]
                    end
                end
                cce_pkg::CCE_EXEC_CALL_JUMP: begin
                    exec_state <= cce_pkg::CCE_EXEC_ISSUE;
                end
                default: begin
                    exec_state <= cce_pkg::CCE_EXEC_ISSUE;
                end
            endcase
        end
    end

    // Ready drops for exactly the extra call cycle
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            instr_ready_o <= 1'b1;
        end else begin
            instr_ready_o <= !do_call; // [RULE3]
        end
    end

    // First call cycle: push the return address, no condition checked
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            stack_push_o <= 1'b0;
            stack_data_o <= cce_pkg::PC_RESET_VALUE[PC_WIDTH-1:0];
        end else begin
            stack_push_o <= do_call; // [RULE1]
            if (do_call) begin
                stack_data_o <= return_addr; // [RULE1]
            end
        end
    end

    // Target held from issue so a changing input cannot corrupt the jump
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            jump_target <= cce_pkg::PC_RESET_VALUE[PC_WIDTH-1:0];
        end else if (do_call) begin
            jump_target <= call_target_i;
        end
    end

    // Second call cycle: load the program counter after the push
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pc_load_o      <= 1'b0;
            pc_load_addr_o <= cce_pkg::PC_RESET_VALUE[PC_WIDTH-1:0];
        end else begin
            pc_load_o <= (exec_state == cce_pkg::CCE_EXEC_CALL_JUMP); // [RULE2]
            if (exec_state == cce_pkg::CCE_EXEC_CALL_JUMP) begin
                pc_load_addr_o <= jump_target; // [RULE2]
            end
        end
    end

    // Masked write avoids a read-modify-write: untouched bits are never rewritten
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            mem_we_o    <= 1'b0;
            mem_addr_o  <= cce_pkg::MEM_ADDR_RESET_VALUE[MEM_ADDR_WIDTH-1:0];
            mem_wdata_o <= cce_pkg::MEM_CLEAR_VALUE[DATA_WIDTH-1:0];
            mem_wmask_o <= cce_pkg::NO_BYTE_MASK[DATA_WIDTH-1:0];
        end else begin
            mem_we_o    <= do_byte_zero || do_bit_zero;
            mem_wdata_o <= cce_pkg::MEM_CLEAR_VALUE[DATA_WIDTH-1:0]; // [RULE4] [RULE5]
            if (do_byte_zero) begin
                mem_addr_o  <= mem_addr_i;
                mem_wmask_o <= cce_pkg::FULL_BYTE_MASK[DATA_WIDTH-1:0]; // [RULE4]
            end else if (do_bit_zero) begin
                mem_addr_o  <= mem_addr_i;
                mem_wmask_o <= bit_mask(bit_sel_i); // [RULE5]
            end else begin
                mem_wmask_o <= cce_pkg::NO_BYTE_MASK[DATA_WIDTH-1:0];
            end
        end
    end

    // Watchdog counter reset strobe, single clear or completed pair only
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            watchdog_counter_clear_o <= 1'b0;
        end else begin
            watchdog_counter_clear_o <= flag_clear; // [RULE6] [RULE7] [RULE8] [RULE9]
        end
    end

    // Time-out flag; a set from the watchdog wins over a clear in the same cycle
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            timeout_status_flag_o <= cce_pkg::FLAG_RESET_VALUE;
        end else if (timeout_set_i) begin
            timeout_status_flag_o <= 1'b1;
        end else if (flag_clear) begin
            timeout_status_flag_o <= 1'b0; // [RULE6] [RULE10]
        end
    end

    // Power-down flag; same priority so a halt is never lost
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            powerdown_status_flag_o <= cce_pkg::FLAG_RESET_VALUE;
        end else if (powerdown_set_i) begin
            powerdown_status_flag_o <= 1'b1;
        end else if (flag_clear) begin
            powerdown_status_flag_o <= 1'b0; // [RULE6] [RULE10]
        end
    end

    // Exposes a half-done pair for debug; mirrors the tracker one cycle late
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            preclear_armed_o <= 1'b0; // [RULE11]
        end else begin
            preclear_armed_o <= pair_armed;
        end
    end

endmodule
`default_nettype wire

// file: src/cce_pkg.sv
`default_nettype none
package cce_pkg;

    // Datapath widths of the core around this block
    localparam int PC_WIDTH        = 11;
    localparam int MEM_ADDR_WIDTH  = 7;
    localparam int DATA_WIDTH      = 8;
    localparam int BIT_SEL_WIDTH   = 3;
    localparam int OP_WIDTH        = 3;

    // Decoded instruction classes handed in by the fetch/decode stage
    localparam logic [2:0] OP_NONE                   = 3'h0;
    localparam logic [2:0] OP_CALL                   = 3'h1;
    localparam logic [2:0] OP_MEMORY_BYTE_ZERO       = 3'h2;
    localparam logic [2:0] OP_MEMORY_BIT_ZERO        = 3'h3;
    localparam logic [2:0] OP_WATCHDOG_CLEAR_SINGLE  = 3'h4;
    localparam logic [2:0] OP_WATCHDOG_PRECLEAR_FIRST  = 3'h5;
    localparam logic [2:0] OP_WATCHDOG_PRECLEAR_SECOND = 3'h6;

    // Values written by the clear instructions
    localparam logic [7:0] MEM_CLEAR_VALUE = 8'h00;
    localparam logic [7:0] FULL_BYTE_MASK  = 8'hFF;
    localparam logic [7:0] NO_BYTE_MASK    = 8'h00;

    // Return address is the call's own address plus this step
    localparam int RETURN_OFFSET = 1;

    // Instruction cycles taken by a subroutine call
    localparam int CALL_CYCLES = 2;

    // Reset values of the status flags and the bus outputs
    localparam logic FLAG_RESET_VALUE = 1'b0;
    localparam logic [10:0] PC_RESET_VALUE = 11'h000;
    localparam logic [6:0] MEM_ADDR_RESET_VALUE = 7'h00;

    // Which half of the paired watchdog pre-clear ran last
    typedef enum logic [1:0] {
        CCE_HALF_NONE,
        CCE_HALF_FIRST,
        CCE_HALF_SECOND
    } cce_half_type;

    // Execution phase of the block
    typedef enum logic {
        CCE_EXEC_ISSUE,
        CCE_EXEC_CALL_JUMP
    } cce_exec_type;

endpackage
`default_nettype wire

// file: src/cce_pair_tracker.sv
`timescale 1ns/1ps
`default_nettype none
module cce_pair_tracker (
    input  wire logic ref_clk_i,
    input  wire logic nrst_i,
    input  wire logic first_i,
    input  wire logic second_i,
    output logic      fire_o,
    output logic      armed_o
);

    cce_pkg::cce_half_type last_half;
    cce_pkg::cce_half_type next_last_half;

    // A half fires only when the opposite half ran last; a repeat only re-arms
    always_comb begin
        fire_o         = 1'b0;
        next_last_half = last_half;
        if (first_i) begin
            if (last_half == cce_pkg::CCE_HALF_SECOND) begin
                fire_o         = 1'b1; // [RULE7] [RULE10]
                next_last_half = cce_pkg::CCE_HALF_NONE;
            end else begin
                next_last_half = cce_pkg::CCE_HALF_FIRST; // [RULE9]
            end
        end else if (second_i) begin
            if (last_half == cce_pkg::CCE_HALF_FIRST) begin
                fire_o         = 1'b1; // [RULE8] [RULE10]
                next_last_half = cce_pkg::CCE_HALF_NONE;
            end else begin
                next_last_half = cce_pkg::CCE_HALF_SECOND; // [RULE9]
            end
        end
    end

    // Pair state; reset drops any half-completed pair
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            last_half <= cce_pkg::CCE_HALF_NONE; // [RULE11]
        end else begin
            last_half <= next_last_half;
        end
    end

    assign armed_o = (last_half != cce_pkg::CCE_HALF_NONE);

endmodule
`default_nettype wire

// file: sim/cce_execute_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module cce_execute_asserts #(
    parameter int PC_WIDTH       = 11,
    parameter int MEM_ADDR_WIDTH = 7,
    parameter int DATA_WIDTH     = 8,
    parameter int BIT_SEL_WIDTH  = 3
) (
    input wire logic                      ref_clk_i,
    input wire logic                      nrst_i,
    input wire logic                      instr_valid_i,
    input wire logic [2:0]                instr_op_i,
    input wire logic [PC_WIDTH-1:0]       pc_i,
    input wire logic [PC_WIDTH-1:0]       call_target_i,
    input wire logic [MEM_ADDR_WIDTH-1:0] mem_addr_i,
    input wire logic [BIT_SEL_WIDTH-1:0]  bit_sel_i,
    input wire logic                      timeout_set_i,
    input wire logic                      powerdown_set_i,
    input wire logic                      instr_ready_o,
    input wire logic                      stack_push_o,
    input wire logic [PC_WIDTH-1:0]       stack_data_o,
    input wire logic                      pc_load_o,
    input wire logic [PC_WIDTH-1:0]       pc_load_addr_o,
    input wire logic                      mem_we_o,
    input wire logic [MEM_ADDR_WIDTH-1:0] mem_addr_o,
    input wire logic [DATA_WIDTH-1:0]     mem_wdata_o,
    input wire logic [DATA_WIDTH-1:0]     mem_wmask_o,
    input wire logic                      watchdog_counter_clear_o,
    input wire logic                      timeout_status_flag_o,
    input wire logic                      powerdown_status_flag_o,
    input wire logic                      preclear_armed_o
);
    // Offers only count while the block is in its issue phase
    wire taken;
    wire no_set;
    assign taken  = instr_valid_i && instr_ready_o;
    assign no_set = !timeout_set_i && !powerdown_set_i;

    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!nrst_i);

    // Taken offers of the call class and of each pre-clear half
    sequence call_s;   taken && instr_op_i == cce_pkg::OP_CALL; endsequence
    sequence first_s;  taken && instr_op_i == cce_pkg::OP_WATCHDOG_PRECLEAR_FIRST; endsequence
    sequence second_s; taken && instr_op_i == cce_pkg::OP_WATCHDOG_PRECLEAR_SECOND; endsequence

    call_push_a: assert property (call_s |=> stack_push_o && !instr_ready_o &&
        stack_data_o == $past(pc_i) + 1'b1) else $error("call push wrong");
    call_jump_a: assert property (call_s |=> !pc_load_o ##1 pc_load_o &&
        pc_load_addr_o == $past(call_target_i, 2)) else $error("call jump wrong");
    call_flags_a: assert property (call_s ##0 no_set |=> $stable(timeout_status_flag_o) &&
        $stable(powerdown_status_flag_o)) else $error("call moved a flag");
    byte_zero_a: assert property (taken && instr_op_i == cce_pkg::OP_MEMORY_BYTE_ZERO |=> mem_we_o &&
        mem_wmask_o == 8'hFF && mem_wdata_o == 8'h00 && mem_addr_o == $past(mem_addr_i))
        else $error("byte clear wrong");
    bit_zero_a: assert property (taken && instr_op_i == cce_pkg::OP_MEMORY_BIT_ZERO |=> mem_we_o &&
        mem_wdata_o == 8'h00 && mem_wmask_o == (8'h01 << $past(bit_sel_i))) else $error("bit clear wrong");
    single_clear_a: assert property (taken && instr_op_i == cce_pkg::OP_WATCHDOG_CLEAR_SINGLE && no_set
        |=> watchdog_counter_clear_o && !timeout_status_flag_o && !powerdown_status_flag_o)
        else $error("single clear wrong");
    pair_fires_a: assert property (first_s ##1 (second_s and !watchdog_counter_clear_o)
        |=> watchdog_counter_clear_o) else $error("pair did not clear");
    repeat_half_a: assert property (first_s ##1 first_s |=> !watchdog_counter_clear_o)
        else $error("repeated half acted");
    flag_fall_a: assert property ($fell(timeout_status_flag_o) || $fell(powerdown_status_flag_o)
        |-> watchdog_counter_clear_o) else $error("flag fell without clear");
endmodule

bind cce_execute cce_execute_asserts #(.PC_WIDTH(PC_WIDTH), .MEM_ADDR_WIDTH(MEM_ADDR_WIDTH),
    .DATA_WIDTH(DATA_WIDTH), .BIT_SEL_WIDTH(BIT_SEL_WIDTH)) u_chk (
    .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .instr_valid_i(instr_valid_i), .instr_op_i(instr_op_i),
    .pc_i(pc_i), .call_target_i(call_target_i), .mem_addr_i(mem_addr_i), .bit_sel_i(bit_sel_i),
    .timeout_set_i(timeout_set_i), .powerdown_set_i(powerdown_set_i), .instr_ready_o(instr_ready_o),
    .stack_push_o(stack_push_o), .stack_data_o(stack_data_o), .pc_load_o(pc_load_o),
    .pc_load_addr_o(pc_load_addr_o), .mem_we_o(mem_we_o), .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o),
    .mem_wmask_o(mem_wmask_o), .watchdog_counter_clear_o(watchdog_counter_clear_o),
    .timeout_status_flag_o(timeout_status_flag_o), .powerdown_status_flag_o(powerdown_status_flag_o),
    .preclear_armed_o(preclear_armed_o));
`default_nettype wire

// file: sim/cce_execute_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module cce_execute_tb_top;
    typedef struct packed {
        logic [2:0]  op;
        logic [10:0] pc;
        logic [10:0] tgt;
        logic [6:0]  addr;
        logic [2:0]  bsel;
        logic [10:0] ret;
        logic [7:0]  mask;
        logic        push;
        logic        clr;
        logic        flag;
    } cce_row_type;

    logic        clk, nrst, valid, to_set, pd_set, ready, push, pld, we, wclr, to_flag, pd_flag, armed;
    logic [2:0]  op, bsel;
    logic [10:0] pc, tgt, sdata, pladdr;
    logic [6:0]  addr, maddr;
    logic [7:0]  wdata, wmask;
    int          n_errors, checks_done;

    // Ordinary cases: offer, then what cycle+1 must show; flags were set beforehand
    cce_row_type rows [9] = '{
        '{cce_pkg::OP_CALL, 11'h7FF, 11'h123, 7'h00, 3'h0, 11'h000, 8'h00, 1'b1, 1'b0, 1'b1},
        '{cce_pkg::OP_CALL, 11'h010, 11'h7FF, 7'h00, 3'h0, 11'h011, 8'h00, 1'b1, 1'b0, 1'b1},
        '{cce_pkg::OP_MEMORY_BYTE_ZERO, 11'h000, 11'h000, 7'h55, 3'h0, 11'h000, 8'hFF, 1'b0, 1'b0, 1'b1},
        '{cce_pkg::OP_MEMORY_BIT_ZERO, 11'h000, 11'h000, 7'h01, 3'h0, 11'h000, 8'h01, 1'b0, 1'b0, 1'b1},
        '{cce_pkg::OP_MEMORY_BIT_ZERO, 11'h000, 11'h000, 7'h7F, 3'h7, 11'h000, 8'h80, 1'b0, 1'b0, 1'b1},
        '{cce_pkg::OP_MEMORY_BIT_ZERO, 11'h000, 11'h000, 7'h20, 3'h3, 11'h000, 8'h08, 1'b0, 1'b0, 1'b1},
        '{3'h7, 11'h000, 11'h000, 7'h00, 3'h0, 11'h000, 8'h00, 1'b0, 1'b0, 1'b1},
        '{cce_pkg::OP_NONE, 11'h000, 11'h000, 7'h00, 3'h0, 11'h000, 8'h00, 1'b0, 1'b0, 1'b1},
        '{cce_pkg::OP_WATCHDOG_CLEAR_SINGLE, 11'h000, 11'h000, 7'h00, 3'h0, 11'h000, 8'h00, 1'b0, 1'b1, 1'b0}};

    cce_execute DUT (.ref_clk_i(clk), .nrst_i(nrst), .instr_valid_i(valid), .instr_op_i(op), .pc_i(pc),
        .call_target_i(tgt), .mem_addr_i(addr), .bit_sel_i(bsel), .timeout_set_i(to_set),
        .powerdown_set_i(pd_set), .instr_ready_o(ready), .stack_push_o(push), .stack_data_o(sdata),
        .pc_load_o(pld), .pc_load_addr_o(pladdr), .mem_we_o(we), .mem_addr_o(maddr), .mem_wdata_o(wdata),
        .mem_wmask_o(wmask), .watchdog_counter_clear_o(wclr), .timeout_status_flag_o(to_flag),
        .powerdown_status_flag_o(pd_flag), .preclear_armed_o(armed));

    task automatic chk_bit(input string what, input logic exp, input logic got);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %b, seen %b", what, exp, got);
        end
    endtask

    task automatic chk_vec(input string what, input logic [10:0] exp, input logic [10:0] got);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    // One-cycle offer; returns at the falling edge where cycle+1 is visible
    task automatic offer(input logic [2:0] o);
        @(negedge clk);
        valid = 1'b1;
        op = o;
        @(negedge clk);
        valid = 1'b0;
    endtask

    task automatic set_flags;
        @(negedge clk);
        {to_set, pd_set} = 2'b11;
        @(negedge clk);
        {to_set, pd_set} = 2'b00;
    endtask

    task automatic chk_clear(input logic c, input logic f);
        chk_bit("clear", c, wclr);
        chk_bit("timeout", f, to_flag);
        chk_bit("powerdown", f, pd_flag);
    endtask

    task automatic end_of_test;
        $display("checks %0d, mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // Whole run is about 60 cycles; this cuts a hang short
    initial begin
        #(2000 * 25);
        n_errors++;
        end_of_test();
    end

    initial begin
        {nrst, valid, to_set, pd_set, op, pc, tgt, addr, bsel} = '0;
        repeat (4) @(negedge clk);
        nrst = 1'b1;
        set_flags();
        foreach (rows[i]) begin
            {pc, tgt, addr, bsel} = {rows[i].pc, rows[i].tgt, rows[i].addr, rows[i].bsel};
            offer(rows[i].op);
            chk_bit("push", rows[i].push, push);
            chk_bit("ready", !rows[i].push, ready);
            if (rows[i].push) chk_vec("return", rows[i].ret, sdata);
            chk_bit("write", rows[i].mask != 8'h00, we);
            chk_vec("mask", {3'h0, rows[i].mask}, {3'h0, wmask});
            if (we === 1'b1) chk_vec("address", {4'h0, rows[i].addr}, {4'h0, maddr});
            if (we === 1'b1) chk_vec("data", {3'h0, cce_pkg::MEM_CLEAR_VALUE}, {3'h0, wdata});
            chk_clear(rows[i].clr, rows[i].flag);
            if (rows[i].push) begin
                @(negedge clk);
                chk_bit("jump", 1'b1, pld);
                chk_vec("target", rows[i].tgt, pladdr);
            end
        end
        $display("table done");
        // Offer held into the call's second cycle must be ignored
        @(negedge clk);
        {valid, op, pc, tgt} = {1'b1, cce_pkg::OP_CALL, 11'h100, 11'h2AA};
        @(negedge clk);
        op = cce_pkg::OP_MEMORY_BYTE_ZERO;
        chk_bit("ready", 1'b0, ready);
        @(negedge clk);
        valid = 1'b0;
        chk_bit("write", 1'b0, we);
        chk_bit("jump", 1'b1, pld);
        $display("refusal done");
        set_flags();
        offer(cce_pkg::OP_WATCHDOG_PRECLEAR_FIRST);
        chk_clear(1'b0, 1'b1);
        offer(cce_pkg::OP_WATCHDOG_PRECLEAR_SECOND);
        chk_clear(1'b1, 1'b0);
        $display("pair done");
        set_flags();
        offer(cce_pkg::OP_WATCHDOG_PRECLEAR_SECOND);
        chk_clear(1'b0, 1'b1);
        offer(cce_pkg::OP_WATCHDOG_PRECLEAR_SECOND);
        chk_clear(1'b0, 1'b1);
        offer(cce_pkg::OP_WATCHDOG_PRECLEAR_FIRST);
        chk_clear(1'b1, 1'b0);
        $display("repeat done");
        // Halves back to back, then a set racing a clear
        set_flags();
        {valid, op} = {1'b1, cce_pkg::OP_WATCHDOG_PRECLEAR_FIRST};
        @(negedge clk);
        op = cce_pkg::OP_WATCHDOG_PRECLEAR_SECOND;
        chk_clear(1'b0, 1'b1);
        @(negedge clk);
        op = cce_pkg::OP_WATCHDOG_PRECLEAR_FIRST;
        chk_clear(1'b1, 1'b0);
        @(negedge clk);
        chk_bit("clear", 1'b0, wclr);
        @(negedge clk);
        valid = 1'b0;
        chk_bit("clear", 1'b0, wclr);
        set_flags();
        @(negedge clk);
        {valid, op, to_set} = {1'b1, cce_pkg::OP_WATCHDOG_CLEAR_SINGLE, 1'b1};
        @(negedge clk);
        {valid, to_set} = 2'b00;
        chk_bit("clear", 1'b1, wclr);
        chk_bit("timeout", 1'b1, to_flag);
        chk_bit("powerdown", 1'b0, pd_flag);
        $display("back to back done");
        // A half pending across a reset must not complete a pair
        offer(cce_pkg::OP_WATCHDOG_PRECLEAR_FIRST);
        chk_bit("armed", 1'b1, armed);
        nrst = 1'b0;
        @(negedge clk);
        nrst = 1'b1;
        set_flags();
        chk_bit("armed", 1'b0, armed);
        offer(cce_pkg::OP_WATCHDOG_PRECLEAR_SECOND);
        chk_clear(1'b0, 1'b1);
        $display("reset done");
        end_of_test();
    end
endmodule
`default_nettype wire
